// ---- include/tgelt_consts.svh ----
// constant names for the timestamp and latency datapath
`ifndef TGELT_CONSTS_SVH
`define TGELT_CONSTS_SVH
// register byte offsets
`define TGELT_OFS_CTRL 8'h00
`define TGELT_OFS_STAT 8'h04
`define TGELT_OFS_FILL 8'h08
`define TGELT_OFS_TXCNT 8'h0c
`define TGELT_OFS_CFGP 8'h10
`define TGELT_OFS_CFGR 8'h14
// control bit positions and reset value
`define TGELT_CTL_TSALL 0
`define TGELT_CTL_RXTS 1
`define TGELT_CTL_FECEN 2
`define TGELT_CTL_FECERR 3
`define TGELT_CTRL_RST 4'h0
// config port command fields
`define TGELT_CFGP_WE 31
`define TGELT_CFGP_AH 24
`define TGELT_CFGP_AL 16
// latency counts, in datapath cycles
`define TGELT_LAT_TX32_NEW 8'h0d
`define TGELT_LAT_TX32_1S 8'h1a
`define TGELT_LAT_TX32_OLD 8'h13
`define TGELT_LAT_TX64_NEW 8'h0d
`define TGELT_LAT_TX64_OLD 8'h1b
`define TGELT_LAT_FEC_TX 8'h06
`define TGELT_LAT_1S_TX 8'h05
`define TGELT_LAT_RX32 8'h0b
`define TGELT_LAT_RX32_EB 8'h30
`define TGELT_LAT_RX32_EBMAX 8'h4b
`define TGELT_LAT_RX64 8'h0c
`define TGELT_LAT_RX64_EB 8'h21
`define TGELT_LAT_RX64_EBMAX 8'h2e
`define TGELT_LAT_FEC_RX 8'h01
`define TGELT_LAT_FEC_COR 8'h46
`define TGELT_LAT_FEC_REP 8'h42
// timer format codes
`define TGELT_FMT_TOD 1'b0
`define TGELT_FMT_CF 1'b1
`endif

// ---- include/tgelt_pkg.sv ----
// types shared by the timestamp and latency datapath
package tgelt_pkg;
	typedef logic [79:0] tgelt_ts_t; // {sec48,ns32} or {16'h0,cf64}
	typedef logic [7:0] tgelt_lat_t; // latency in cycles
	typedef logic [3:0] tgelt_ctrl_t; // control register bits
endpackage : tgelt_pkg

// ---- include/tgelt_beat_if.sv ----
// one stream beat passed between the top and the delay lines
`timescale 1ns/10ps
`default_nettype none
interface tgelt_beat_if;
	logic valid; // beat present
	logic last; // end of frame
	logic [7:0] keep; // byte enables
	logic [63:0] data; // payload word
	logic [81:0] user; // {timestamp,good,sof} or fcs pass
	modport src (output valid, last, keep, data, user);
	modport snk (input valid, last, keep, data, user);
endinterface : tgelt_beat_if
`default_nettype wire

// ---- rtl/tgelt_dline.sv ----
// fixed-latency delay line with a selectable depth
`timescale 1ns/10ps
`default_nettype none
module tgelt_dline
	import tgelt_pkg::*;
(
	input wire logic clk, // datapath clock
	input wire logic rst_b, // sync reset, active low
	input wire tgelt_lat_t lat, // latency, at least 2
	tgelt_beat_if.snk din, // beats in
	tgelt_beat_if.src dout // beats out, registered
);
	logic [154:0] mem [0:255]; // beat storage
	logic [255:0] vld_q; // per-entry valid, reset clean
	logic [7:0] wp_q; // write position
	logic [7:0] rp; // read position
	logic [154:0] rd_w; // word read out

	// read the entry written lat-1 edges ago
	assign rp = wp_q - (lat - 8'h01);
	assign rd_w = mem[rp];

	// store every cycle, whether valid or not
	always_ff @(posedge clk) begin
		mem[wp_q] <= {din.last, din.keep, din.data, din.user};
	end

	// valid bits and write pointer advance each cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			vld_q <= '0;
			wp_q <= 8'h00;
		end else begin
			vld_q[wp_q] <= din.valid;
			wp_q <= wp_q + 8'h01;
		end
	end

	// output stage: content-independent fixed delay
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dout.valid <= 1'b0;
			dout.last <= 1'b0;
			dout.keep <= 8'h00;
			dout.data <= 64'h0;
			dout.user <= 82'h0;
		end else begin
			dout.valid <= vld_q[rp];
			dout.last <= rd_w[154] & vld_q[rp];
			dout.keep <= rd_w[153:146];
			dout.data <= rd_w[145:82];
			dout.user <= rd_w[81:0];
		end
	end
endmodule : tgelt_dline
`default_nettype wire

// ---- rtl/tgelt_top.sv ----
// timestamping datapath with fixed pipeline latencies
// Operation
// - hardware stamps both paths, error under 5ns
// - time-of-day: 48-bit seconds plus 32-bit ns
// - correction field: signed 64-bit ns times 2^16
// - timer format is fixed at build time
// - in-band and out-of-band stamp control and reporting
// - stamps reported on separate stream ports
// - timer crossed separately for transmit and receive
// - register port takes single transfers only; the code also accepts seq beats of bursts
// - one-step build: no fcs passing, no vectors
// - training port reaches registers and config port
// - 32-bit newer family transmit: 13 cycles
// - 32-bit one-step correction transmit: 26 cycles
// - 32-bit older families transmit: 19 cycles
// - 32-bit receive without buffer: 11 cycles
// - 32-bit buffered receive: nominal 47.6, max 75
// - 64-bit newer family transmit: 13 cycles
// - 64-bit older families transmit: 27 cycles
// - 64-bit correction enabled adds 6 transmit cycles
// - 64-bit one-step correction adds 5 transmit cycles
// - 64-bit receive without buffer: 12 cycles
// - 64-bit buffered receive: nominal 32.75, max 46.26
// - elastic buffer 32 words, keeps half full
`timescale 1ns/10ps
`default_nettype none
`include "tgelt_consts.svh"
module tgelt_top
	import tgelt_pkg::*;
#(
	parameter bit DP32 = 1'b0, // 32-bit datapath build
	parameter bit NEW_FAM = 1'b1, // newer device family
	parameter bit EB_PRESENT = 1'b0, // receive elastic buffer
	parameter bit FEC_PRESENT = 1'b0, // error correction built in
	parameter bit ONE_STEP = 1'b0, // one-step stamping build
	parameter bit TMR_FMT = `TGELT_FMT_TOD // timer format
) (
	input wire logic clk, // datapath clock
	input wire logic rst_b, // sync reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [2:0] hburst, // ahb burst, single only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic [31:0] hrdata, // ahb read data
	output logic hresp, // ahb response, always okay
	input wire logic trn_req, // training access request
	input wire logic trn_we, // training write
	input wire logic [7:0] trn_addr, // training byte address
	input wire logic [31:0] trn_wdata, // training write data
	output logic trn_ack, // training access done
	output logic [31:0] trn_rdata, // training read data
	output logic cfgp_en, // config port strobe
	output logic cfgp_we, // config port write
	output logic [8:0] cfgp_addr, // config port address
	output logic [15:0] cfgp_di, // config port write data
	input wire logic [15:0] cfgp_do, // config port read data
	input wire logic cfgp_rdy, // config port done
	input wire tgelt_ts_t tmr_val, // system timer value
	input wire logic [63:0] s_tx_tdata, // client tx data
	input wire logic [7:0] s_tx_tkeep, // client tx keep
	input wire logic s_tx_tvalid, // client tx valid
	input wire logic s_tx_tlast, // client tx last
	input wire logic [1:0] s_tx_tuser, // {fcs pass,stamp req}
	output logic s_tx_tready, // client tx ready
	output logic [63:0] serdes_tx_parallel_word, // to serdes
	output logic tx_out_valid, // tx word valid
	output logic [7:0] tx_out_keep, // tx keep
	output logic tx_out_last, // tx end of frame
	output logic tx_out_fcs_pass, // tx fcs passed in-band
	output logic m_txts_tvalid, // tx stamp report valid
	output tgelt_ts_t m_txts_tdata, // tx stamp report
	input wire logic [63:0] serdes_rx_parallel_word, // serdes
	input wire logic rx_in_valid, // rx word valid
	input wire logic [7:0] rx_in_keep, // rx keep
	input wire logic rx_in_last, // rx end of frame
	input wire logic rx_in_good, // rx frame good
	output logic [63:0] m_rx_tdata, // client rx data
	output logic [7:0] m_rx_tkeep, // client rx keep
	output logic m_rx_tvalid, // client rx valid
	output logic m_rx_tlast, // client rx last
	output logic m_rx_tuser, // client rx good frame
	output tgelt_ts_t m_rx_ts, // in-band rx stamp
	output logic m_rxts_tvalid, // rx stamp report valid
	output tgelt_ts_t m_rxts_tdata // rx stamp report
);
	tgelt_beat_if txi(); // tx beats into the delay line
	tgelt_beat_if txo(); // tx beats out
	tgelt_beat_if rxi(); // rx beats in
	tgelt_beat_if rxo(); // rx beats out

	tgelt_ctrl_t ctrl_q, ctrl_d; // control register
	logic [5:0] fill_q, fill_d; // elastic buffer fill excess
	logic [15:0] txcnt_q; // tx stamps issued
	logic txcnt_clr; // clear of tx stamp count
	logic wr_pend_q; // ahb write in data phase
	logic [7:0] wr_addr_q; // its address
	logic wr_en; // a register write this cycle
	logic [7:0] wr_a; // its address
	logic [31:0] wr_d; // its data
	logic trn_go; // training access taken now
	logic ahb_go; // ahb transfer accepted now
	logic cfgp_busy_q; // config port access open
	logic [15:0] cfgp_rd_q; // last config port read
	tgelt_ts_t txt_s1_q, txt_s2_q; // tx timer crossing
	tgelt_ts_t rxt_s1_q, rxt_s2_q; // rx timer crossing
	logic tx_inf_q; // tx frame in progress
	logic rx_inf_q; // rx frame in progress
	logic tx_sof; // first tx beat
	logic rx_sof; // first rx beat
	tgelt_lat_t tx_lat_q; // tx latency in use
	tgelt_lat_t rx_lat_q; // rx latency in use

	// timer in the fixed format
	function automatic tgelt_ts_t ts_fmt(input tgelt_ts_t t);
		if (TMR_FMT == `TGELT_FMT_CF)
			return {16'h0, t[63:0]}; // signed scaled ns
		else
			return t; // seconds and ns fields
	endfunction : ts_fmt

	// transmit latency for a build and controls
	function automatic tgelt_lat_t tx_lat(input logic fec_on);
		tgelt_lat_t l;
		l = `TGELT_LAT_TX64_OLD;
		if (DP32) begin
			if (!NEW_FAM)
				l = `TGELT_LAT_TX32_OLD;
			else if (ONE_STEP && TMR_FMT == `TGELT_FMT_CF)
				l = `TGELT_LAT_TX32_1S;
			else
				l = `TGELT_LAT_TX32_NEW;
		end else begin
			if (NEW_FAM)
				l = `TGELT_LAT_TX64_NEW;
			else
				l = `TGELT_LAT_TX64_OLD;
			if (FEC_PRESENT && fec_on)
				l = l + `TGELT_LAT_FEC_TX;
			if (ONE_STEP && TMR_FMT == `TGELT_FMT_CF)
				l = l + `TGELT_LAT_1S_TX;
		end
		return l;
	endfunction : tx_lat

	// receive latency; buffered cases follow the fill excess
	function automatic tgelt_lat_t rx_lat(input tgelt_ctrl_t c,
		input logic [5:0] f);
		tgelt_lat_t l;
		tgelt_lat_t mx;
		l = `TGELT_LAT_RX64;
		mx = `TGELT_LAT_RX64_EBMAX;
		if (DP32 && !EB_PRESENT)
			l = `TGELT_LAT_RX32;
		else if (DP32) begin
			l = `TGELT_LAT_RX32_EB + {2'b00, f};
			mx = `TGELT_LAT_RX32_EBMAX;
		end else if (!EB_PRESENT)
			l = `TGELT_LAT_RX64;
		else
			l = `TGELT_LAT_RX64_EB + {2'b00, f};
		if (EB_PRESENT && l > mx)
			l = mx; // buffer bound
		if (FEC_PRESENT) begin
			l = l + `TGELT_LAT_FEC_RX;
			if (c[`TGELT_CTL_FECEN])
				l = l + `TGELT_LAT_FEC_COR;
			if (c[`TGELT_CTL_FECEN] && c[`TGELT_CTL_FECERR])
				l = l + `TGELT_LAT_FEC_REP;
		end
		return l;
	endfunction : rx_lat

	// register read decode; unmapped reads return zero
	function automatic logic [31:0] reg_rd(input logic [7:0] a,
		input tgelt_ctrl_t c, input logic [5:0] f);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`TGELT_OFS_CTRL: r = {28'h0, c};
			`TGELT_OFS_STAT: r = {16'h0, rx_lat_q, tx_lat_q};
			`TGELT_OFS_FILL: r = {26'h0, f};
			`TGELT_OFS_TXCNT: r = {16'h0, txcnt_q};
			`TGELT_OFS_CFGR: r = {cfgp_busy_q, 15'h0, cfgp_rd_q};
			default: r = 32'h0;
		endcase
		return r;
	endfunction : reg_rd

	// ahb accepts any nonseq or seq transfer; hsize and hburst are not checked
	assign ahb_go = hsel & htrans[1] & hready;
	// training access uses cycles free of ahb writes
	assign trn_go = trn_req & ~wr_pend_q & ~trn_ack;
	assign wr_en = wr_pend_q | (trn_go & trn_we);
	assign wr_a = wr_pend_q ? wr_addr_q : trn_addr;
	assign wr_d = wr_pend_q ? hwdata : trn_wdata;
	assign txcnt_clr = wr_en & (wr_a == `TGELT_OFS_TXCNT);

	// next values of the writable registers
	always_comb begin
		ctrl_d = ctrl_q;
		fill_d = fill_q;
		if (wr_en && wr_a == `TGELT_OFS_CTRL)
			ctrl_d = wr_d[3:0];
		if (wr_en && wr_a == `TGELT_OFS_FILL)
			fill_d = wr_d[5:0];
	end

	// writable registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= `TGELT_CTRL_RST;
			fill_q <= 6'h00;
		end else begin
			ctrl_q <= ctrl_d;
			fill_q <= fill_d;
		end
	end

	// ahb slave: zero wait, write data taken in data phase
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_pend_q <= ahb_go & hwrite;
			if (ahb_go)
				wr_addr_q <= haddr[7:0];
			// read sees a ctrl or fill write finishing in the same edge
			if (ahb_go && !hwrite)
				hrdata <= reg_rd(haddr[7:0], ctrl_d, fill_d);
		end
	end

	// training port answers one cycle after it is taken
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			trn_ack <= 1'b0;
			trn_rdata <= 32'h0;
		end else begin
			trn_ack <= trn_go;
			if (trn_go && !trn_we)
				trn_rdata <= reg_rd(trn_addr, ctrl_q, fill_q);
		end
	end

	// transceiver config port driven by command writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfgp_en <= 1'b0;
			cfgp_we <= 1'b0;
			cfgp_addr <= 9'h000;
			cfgp_di <= 16'h0000;
			cfgp_busy_q <= 1'b0;
			cfgp_rd_q <= 16'h0000;
		end else begin
			cfgp_en <= 1'b0;
			if (wr_en && wr_a == `TGELT_OFS_CFGP && !cfgp_busy_q) begin
				cfgp_en <= 1'b1;
				cfgp_we <= wr_d[`TGELT_CFGP_WE];
				cfgp_addr <= wr_d[`TGELT_CFGP_AH:`TGELT_CFGP_AL];
				cfgp_di <= wr_d[15:0];
				cfgp_busy_q <= 1'b1;
			end else if (cfgp_busy_q && cfgp_rdy) begin
				cfgp_busy_q <= 1'b0;
				cfgp_rd_q <= cfgp_do;
			end
		end
	end

	// timer crossing, a separate pair per path
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txt_s1_q <= 80'h0;
			txt_s2_q <= 80'h0;
			rxt_s1_q <= 80'h0;
			rxt_s2_q <= 80'h0;
		end else begin
			txt_s1_q <= tmr_val;
			txt_s2_q <= txt_s1_q;
			rxt_s1_q <= tmr_val;
			rxt_s2_q <= rxt_s1_q;
		end
	end

	// latencies held in registers; change takes one cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_lat_q <= `TGELT_LAT_TX64_NEW;
			rx_lat_q <= `TGELT_LAT_RX64;
		end else begin
			tx_lat_q <= tx_lat(ctrl_q[`TGELT_CTL_FECEN]);
			rx_lat_q <= rx_lat(ctrl_q, fill_q);
		end
	end

	// frame tracking marks the first beat of each frame
	assign tx_sof = s_tx_tvalid & ~tx_inf_q;
	assign rx_sof = rx_in_valid & ~rx_inf_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_inf_q <= 1'b0;
			rx_inf_q <= 1'b0;
		end else begin
			if (s_tx_tvalid)
				tx_inf_q <= ~s_tx_tlast;
			if (rx_in_valid)
				rx_inf_q <= ~rx_in_last;
		end
	end

	// tx stamp: per-frame request or stamp-all
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			m_txts_tvalid <= 1'b0;
			m_txts_tdata <= 80'h0;
			txcnt_q <= 16'h0000;
		end else begin
			m_txts_tvalid <= 1'b0;
			if (tx_sof && (s_tx_tuser[0] || ctrl_q[`TGELT_CTL_TSALL]))
			begin
				m_txts_tvalid <= 1'b1;
				m_txts_tdata <= ts_fmt(txt_s2_q);
			end
			// a stamp in the clearing cycle still counts
			if (txcnt_clr)
				txcnt_q <= {15'h0, m_txts_tvalid};
			else if (m_txts_tvalid)
				txcnt_q <= txcnt_q + 16'h0001;
		end
	end

	// client tx always accepted; no stall in this path
	always_ff @(posedge clk) begin
		if (!rst_b)
			s_tx_tready <= 1'b0;
		else
			s_tx_tready <= 1'b1;
	end

	// tx beats into the pipeline; one-step drops fcs pass
	assign txi.valid = s_tx_tvalid & s_tx_tready;
	assign txi.last = s_tx_tlast;
	assign txi.keep = s_tx_tkeep;
	assign txi.data = s_tx_tdata;
	assign txi.user = {81'h0, s_tx_tuser[1] & ~ONE_STEP};

	// rx beats carry their stamp on the first beat
	assign rxi.valid = rx_in_valid;
	assign rxi.last = rx_in_last;
	assign rxi.keep = rx_in_keep;
	assign rxi.data = serdes_rx_parallel_word;
	assign rxi.user = {ts_fmt(rxt_s2_q), rx_in_good, rx_sof};

	// transmit pipeline
	tgelt_dline u_txd (
		.clk(clk),
		.rst_b(rst_b),
		.lat(tx_lat_q),
		.din(txi),
		.dout(txo)
	);

	// receive pipeline
	tgelt_dline u_rxd (
		.clk(clk),
		.rst_b(rst_b),
		.lat(rx_lat_q),
		.din(rxi),
		.dout(rxo)
	);

	// tx line outputs come from the delay line flops
	assign serdes_tx_parallel_word = txo.data;
	assign tx_out_valid = txo.valid;
	assign tx_out_keep = txo.keep;
	assign tx_out_last = txo.last;
	assign tx_out_fcs_pass = txo.user[0];

	// rx client outputs, in-band stamp beside data
	assign m_rx_tdata = rxo.data;
	assign m_rx_tkeep = rxo.keep;
	assign m_rx_tvalid = rxo.valid;
	assign m_rx_tlast = rxo.last;
	assign m_rx_tuser = rxo.user[1];
	assign m_rx_ts = rxo.user[81:2];

	// out-of-band rx stamp, one cycle after first beat
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			m_rxts_tvalid <= 1'b0;
			m_rxts_tdata <= 80'h0;
		end else begin
			m_rxts_tvalid <= rxo.valid & rxo.user[0] &
				ctrl_q[`TGELT_CTL_RXTS];
			if (rxo.valid && rxo.user[0])
				m_rxts_tdata <= rxo.user[81:2];
		end
	end
endmodule : tgelt_top
`default_nettype wire

// ---- tb/tgelt_chk.sv ----
// assertions on the ports of the timestamp latency datapath
`timescale 1ns/10ps
`default_nettype none
module tgelt_chk (
	input wire logic clk, // datapath clock
	input wire logic rst_b, // sync reset, active low
	input wire logic hsel, // ahb select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	input wire logic hreadyout, // ahb slave ready
	input wire logic hresp, // ahb response
	input wire logic trn_req, // training request
	input wire logic trn_ack, // training done
	input wire logic [63:0] s_tx_tdata, // client tx data
	input wire logic s_tx_tvalid, // client tx valid
	input wire logic s_tx_tlast, // client tx last
	input wire logic [1:0] s_tx_tuser, // client tx user
	input wire logic [63:0] serdes_tx_parallel_word, // tx word
	input wire logic tx_out_valid, // tx word valid
	input wire logic rx_in_valid, // rx word valid
	input wire logic m_rx_tvalid, // client rx valid
	input wire logic m_txts_tvalid // tx stamp valid
);
	logic wdp_q; // an ahb write is in its data phase
	logic [7:0] wad_q; // address of that write
	logic [3:0] ctl_q; // shadow of the control register
	logic sof_q; // next tx beat opens a frame
	// shadow ahb writes so the latency mode is known here
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wdp_q <= 1'b0;
			wad_q <= 8'h00;
			ctl_q <= 4'h0;
		end else begin
			wdp_q <= hsel && htrans[1] && hready && hwrite;
			wad_q <= haddr[7:0];
			if (wdp_q && wad_q == 8'h00) begin
				ctl_q <= hwdata[3:0];
			end
		end
	end
	// track frame starts on the client tx stream
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sof_q <= 1'b1;
		end else if (s_tx_tvalid) begin
			sof_q <= s_tx_tlast;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence trn_taken;
		trn_req && !trn_ack && !wdp_q;
	endsequence
	sequence tx_first_req;
		s_tx_tvalid && sof_q && s_tx_tuser[0];
	endsequence
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("ahb response not okay");
	ready_high_a: assert property (hreadyout)
		else $error("ahb slave inserted a wait");
	tx_plain_a: assert property (
		s_tx_tvalid && !ctl_q[2] |-> ##13 (tx_out_valid &&
		serdes_tx_parallel_word == $past(s_tx_tdata, 13)))
		else $error("tx word late or wrong at base latency");
	tx_fec_a: assert property (
		s_tx_tvalid && ctl_q[2] |-> ##19 (tx_out_valid &&
		serdes_tx_parallel_word == $past(s_tx_tdata, 19)))
		else $error("tx word late or wrong with correction on");
	rx_plain_a: assert property (
		rx_in_valid && !ctl_q[2] |-> ##13 m_rx_tvalid)
		else $error("rx word late at base latency");
	rx_full_a: assert property (
		rx_in_valid && ctl_q[3:2] == 2'b11 |-> ##149 m_rx_tvalid)
		else $error("rx word late with correction and reporting");
	stamp_req_a: assert property (
		tx_first_req |=> m_txts_tvalid)
		else $error("requested tx stamp not reported");
	trn_ack_a: assert property (trn_taken |=> trn_ack)
		else $error("training access not answered");
endmodule : tgelt_chk
bind tgelt_top tgelt_chk chk_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .trn_req, .trn_ack, .s_tx_tdata,
	.s_tx_tvalid, .s_tx_tlast, .s_tx_tuser, .serdes_tx_parallel_word,
	.tx_out_valid, .rx_in_valid, .m_rx_tvalid, .m_txts_tvalid);
`default_nettype wire

// ---- tb/tgelt_far_model.sv ----
// far side model: serdes loopback, timer source and config port
`timescale 1ns/10ps
`default_nettype none
module tgelt_far_model
	import tgelt_pkg::*;
(
	input wire logic clk, // datapath clock
	input wire logic rst_b, // sync reset, active low
	input wire logic [63:0] serdes_tx_parallel_word, // tx word
	input wire logic tx_out_valid, // tx word valid
	input wire logic [7:0] tx_out_keep, // tx keep
	input wire logic tx_out_last, // tx last
	input wire logic cfgp_en, // config strobe
	input wire logic [8:0] cfgp_addr, // config address
	output logic [63:0] serdes_rx_parallel_word, // rx word
	output logic rx_in_valid, // rx word valid
	output logic [7:0] rx_in_keep, // rx keep
	output logic rx_in_last, // rx last
	output logic rx_in_good, // rx frame good
	output logic [15:0] cfgp_do, // config read data
	output logic cfgp_rdy, // config done
	output tgelt_ts_t tmr_val // system timer
);
	logic [1:0] cw_q; // config answer countdown
	// loop tx words back; idle data and keep invert their previous value each cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rx_in_valid <= 1'b0;
			serdes_rx_parallel_word <= 64'h0;
			rx_in_keep <= 8'h00;
			rx_in_last <= 1'b0;
		end else begin
			rx_in_valid <= tx_out_valid;
			serdes_rx_parallel_word <= tx_out_valid ?
				serdes_tx_parallel_word : ~serdes_rx_parallel_word;
			rx_in_keep <= tx_out_valid ? tx_out_keep : ~rx_in_keep;
			rx_in_last <= tx_out_valid && tx_out_last;
		end
	end
	assign rx_in_good = 1'b1;
	// time-of-day nanoseconds step one period upward from zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tmr_val <= 80'h0;
		end else begin
			tmr_val <= tmr_val + 80'h32;
		end
	end
	// config port answers four cycles after each strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cw_q <= 2'h0;
			cfgp_rdy <= 1'b0;
			cfgp_do <= 16'h0;
		end else begin
			cfgp_rdy <= cw_q == 2'h1;
			cfgp_do <= (cw_q == 2'h1) ? {7'h0, cfgp_addr} : ~cfgp_do;
			if (cfgp_en) begin
				cw_q <= 2'h3;
			end else if (cw_q != 2'h0) begin
				cw_q <= cw_q - 2'h1;
			end
		end
	end
endmodule : tgelt_far_model
`default_nettype wire

// ---- tb/tgelt_tb_top.sv ----
// self-checking bench of the timestamp latency datapath
`timescale 1ns/10ps
`default_nettype none
`include "tgelt_consts.svh"
module tgelt_tb_top
	import tgelt_pkg::*;
;
	logic clk, rst_b, hsel, hwrite, hreadyout, hresp, trn_req, trn_we, trn_ack;
	logic [31:0] haddr, hwdata, hrdata, trn_wdata, trn_rdata, seed, r;
	logic [1:0] htrans, s_tx_tuser;
	logic [7:0] trn_addr, s_tx_tkeep, tx_out_keep, rx_in_keep, m_rx_tkeep;
	logic cfgp_en, cfgp_we, cfgp_rdy, s_tx_tvalid, s_tx_tlast, s_tx_tready;
	logic [8:0] cfgp_addr;
	logic [15:0] cfgp_di, cfgp_do;
	logic [63:0] s_tx_tdata, serdes_tx_parallel_word, serdes_rx_parallel_word;
	logic [63:0] m_rx_tdata;
	logic tx_out_valid, tx_out_last, tx_out_fcs_pass, m_txts_tvalid, rx_in_valid;
	logic rx_in_last, rx_in_good, m_rx_tvalid, m_rx_tlast, m_rx_tuser, m_rxts_tvalid;
	tgelt_ts_t tmr_val, m_txts_tdata, m_rx_ts, m_rxts_tdata;
	logic [3:0] ctl; // control value under test
	logic [73:0] txq[$], rxq[$], e; // expected {fcs,last,keep,data}
	int fails, samples_checked, cyc, cnt;
	tgelt_top #(.FEC_PRESENT(1'b1)) dut_u (.clk, .rst_b, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hburst(3'h0), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .trn_req, .trn_we, .trn_addr, .trn_wdata,
		.trn_ack, .trn_rdata, .cfgp_en, .cfgp_we, .cfgp_addr, .cfgp_di, .cfgp_do,
		.cfgp_rdy, .tmr_val, .s_tx_tdata, .s_tx_tkeep, .s_tx_tvalid, .s_tx_tlast,
		.s_tx_tuser, .s_tx_tready, .serdes_tx_parallel_word, .tx_out_valid,
		.tx_out_keep, .tx_out_last, .tx_out_fcs_pass, .m_txts_tvalid,
		.m_txts_tdata, .serdes_rx_parallel_word, .rx_in_valid, .rx_in_keep,
		.rx_in_last, .rx_in_good, .m_rx_tdata, .m_rx_tkeep, .m_rx_tvalid,
		.m_rx_tlast, .m_rx_tuser, .m_rx_ts, .m_rxts_tvalid, .m_rxts_tdata);
	tgelt_far_model far_u (.clk, .rst_b, .serdes_tx_parallel_word, .tx_out_valid,
		.tx_out_keep, .tx_out_last, .cfgp_en, .cfgp_addr, .serdes_rx_parallel_word,
		.rx_in_valid, .rx_in_keep, .rx_in_last, .rx_in_good, .cfgp_do, .cfgp_rdy,
		.tmr_val);
	// pseudo-random step
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// expected {rx,tx} latency for a control value
	function automatic logic [15:0] exp_lat(input logic [3:0] c);
		logic [7:0] t, x;
		t = 8'h0d + (c[2] ? 8'h06 : 8'h00);
		x = 8'h0d + (c[2] ? 8'h46 : 8'h00) + (c[3] && c[2] ? 8'h42 : 8'h00);
		return {x, t};
	endfunction : exp_lat
	// compare and count
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t value %h expected %h", $time, seen, exp);
		end
	endtask : check
	// print the verdict and end
	task stop_test;
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// one ahb-lite single word transfer
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask : ahb
	// one training port access, held until acknowledged
	task trn_access(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		trn_req <= 1'b1;
		trn_we <= w;
		trn_addr <= a;
		trn_wdata <= d;
		@(posedge clk);
		while (trn_ack !== 1'b1) @(posedge clk);
		trn_req <= 1'b0;
	endtask : trn_access
	// one frame of n beats, left valid for back-to-back frames
	task send(input int n, input logic req);
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			@(posedge clk);
			s_tx_tvalid <= 1'b1;
			s_tx_tdata <= {seed, ~seed};
			s_tx_tkeep <= seed[7:0] | 8'h01;
			s_tx_tlast <= i == n - 1;
			s_tx_tuser <= {seed[9], req && i == 0};
			txq.push_back({seed[9], i == n - 1, seed[7:0] | 8'h01,
				seed, ~seed});
		end
	endtask : send
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// output monitors and timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			stop_test;
		end
		if (tx_out_valid === 1'b1) begin
			e = (txq.size() > 0) ? txq.pop_front() :
				~{10'h0, serdes_tx_parallel_word};
			check(serdes_tx_parallel_word, e[63:0]);
			// fcs passing survives in a two-step build
			check({54'h0, tx_out_fcs_pass, tx_out_last, tx_out_keep},
				{54'h0, e[73:64]});
			rxq.push_back(e);
		end
		if (m_rx_tvalid === 1'b1) begin
			e = (rxq.size() > 0) ? rxq.pop_front() : ~{10'h0, m_rx_tdata};
			check(m_rx_tdata, e[63:0]);
			// looped frames are always good
			check({54'h0, m_rx_tuser, m_rx_tlast, m_rx_tkeep},
				{54'h0, 1'b1, e[72:64]});
		end
		if (m_txts_tvalid === 1'b1) begin
			check({63'h0, tmr_val - m_txts_tdata <= 80'hfa}, 64'h1);
		end
	end
	initial begin
		{rst_b, hsel, hwrite, trn_req, trn_we, s_tx_tvalid, s_tx_tlast} = 7'h0;
		{haddr, hwdata, trn_wdata, s_tx_tdata} = 160'h0;
		{htrans, s_tx_tuser, trn_addr, s_tx_tkeep} = 20'h0;
		{fails, samples_checked, cyc, cnt} = 128'h0;
		seed = 32'h5e;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		ahb(1'b0, `TGELT_OFS_STAT, 32'h0);
		check({32'h0, r}, {48'h0, exp_lat(4'h0)});
		ahb(1'b0, 8'h20, 32'h0);
		check({32'h0, r}, 64'h0);
		for (int c = 0; c < 4; c++) begin
			ctl = {c[1:0], seed[1:0]};
			ahb(1'b1, `TGELT_OFS_CTRL, {28'h0, ctl});
			ahb(1'b0, `TGELT_OFS_STAT, 32'h0);
			check({32'h0, r}, {48'h0, exp_lat(ctl)});
			ahb(1'b1, `TGELT_OFS_TXCNT, 32'h0);
			cnt = 0;
			trn_access(1'b1, `TGELT_OFS_FILL, seed);
			trn_access(1'b0, `TGELT_OFS_CTRL, 32'h0);
			check({32'h0, trn_rdata}, {60'h0, ctl});
			ahb(1'b0, `TGELT_OFS_FILL, 32'h0);
			check({32'h0, r}, {58'h0, seed[5:0]});
			for (int f = 1; f < 4; f++) begin
				cnt += (seed[3] | ctl[0]) ? 1 : 0;
				send(f, seed[3]);
			end
			@(posedge clk);
			s_tx_tvalid <= 1'b0;
			repeat (200) @(posedge clk);
			ahb(1'b0, `TGELT_OFS_TXCNT, 32'h0);
			check({32'h0, r}, cnt);
		end
		ahb(1'b1, `TGELT_OFS_CFGP, {1'b0, 6'h0, 9'h0a5, 16'h0});
		repeat (10) @(posedge clk);
		ahb(1'b0, `TGELT_OFS_CFGR, 32'h0);
		check({32'h0, r}, {48'h0, 7'h0, 9'h0a5});
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		ahb(1'b0, `TGELT_OFS_CTRL, 32'h0);
		check({32'h0, r}, 64'h0);
		stop_test;
	end
endmodule : tgelt_tb_top
`default_nettype wire
